// file: bench/cpu_model.sv
`timescale 1ns/100ps
module cpu_model
  import flash_pv_pkg::*;
#(
  parameter int WAIT_CYC = 2
) (
  input  wire logic              clk_i,
  input  wire logic [15:0]       rdata_i,
  input  wire logic              rvalid_i,
  output logic      [6:0]        bits_o,
  output logic                   wr_o,
  output logic                   rd_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [7:0]        wdata_o
);
  initial begin
    bits_o = 7'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 18'h00000;
    wdata_o = 8'h00;
  end
  // One bit per access; the wait count stands for the timed wait
  task set_bit(input int b, input logic v);
    @(negedge clk_i);
    bits_o[b] = v;
    repeat (WAIT_CYC) @(negedge clk_i);
  endtask : set_bit
  // Single byte write; released lines show inverted values
  task wr_byte(input logic [17:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr_byte
  // Dummy erased-byte write, read wait, then one word read
  task rd_word(input logic [17:0] a, output logic [15:0] w);
    int k;
    w = 16'hXXXX;
    wr_byte(a, ERASED_BYTE);
    repeat (WAIT_CYC) @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    for (k = 0; k < 4; k++) begin
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      if (rvalid_i === 1'b1) w = rdata_i;
    end
  endtask : rd_word
endmodule : cpu_model

// file: bench/test_flash_program_verify_seq.sv
`timescale 1ns/100ps
module test_flash_program_verify_seq
  import flash_pv_pkg::*;
;
  localparam int B_EN = 0, B_PS = 1, B_PP = 2, B_PV = 3;
  localparam int B_ES = 4, B_EP = 5, B_EV = 6;
  localparam int          W_EARLY   = 30;
  localparam int          W_LATE    = 200;
  localparam int          W_EXTRA   = 10;
  localparam int          MAX_LOOPS = 20;
  localparam int          GUARD_LIM = 300;
  localparam logic [17:0] PAGE_BASE = 18'h00000;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        flash_write_enable_pin = 1'b1;
  logic [6:0]  bits;
  logic        wr, rd, rvalid, prog, ers;
  logic [17:0] addr;
  logic [7:0]  wdata;
  logic [15:0] rdata;
  logic [2:0]  mode;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          guard_cyc = 0;
  logic [7:0]  rep_img [PAGE_BYTES];
  logic [7:0]  add_img [PAGE_BYTES];
  always #2 ref_clk_i = ~ref_clk_i;
  flash_program_verify_seq DUT (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .flash_write_enable_pin_i(flash_write_enable_pin),
    .software_write_enable_i(bits[0]), .program_setup_bit_i(bits[1]),
    .program_pulse_bit_i(bits[2]), .verify_after_write_bit_i(bits[3]),
    .erase_setup_bit_i(bits[4]), .erase_pulse_bit_i(bits[5]),
    .erase_verify_bit_i(bits[6]), .wr_i(wr), .rd_i(rd), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
    .programming_o(prog), .erasing_o(ers), .mode_o(mode));
  cpu_model cpu (.clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .bits_o(bits), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  ////////////////////////////////////////////////////////////////////////
  // Hang guard: the whole run needs about 2000 cycles; the runaway guard
  // is armed while the setup bit stands, longer than all program waits
  always @(posedge ref_clk_i) begin
    cycles++;
    guard_cyc = bits[B_PS] ? guard_cyc + 1 : 0;
    if (cycles == 20000 || guard_cyc == GUARD_LIM) begin
      miscompares++;
      $display("ERROR limit expected below %0d seen %0d", GUARD_LIM,
        guard_cyc);
      stop_test();
    end
  end
  task check(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task chk_mode(input mode_st_t s);
    check("mode", 16'(s), 16'(mode));
  endtask : chk_mode
  ////////////////////////////////////////////////////////////////////////
  // Every mode except program verify reached and left one bit at a time
  task t_walk;
    logic [15:0] w;
    cpu.set_bit(B_EN, 1'b1);
    chk_mode(ST_ENABLE);
    cpu.set_bit(B_PS, 1'b1);
    chk_mode(ST_PSETUP);
    cpu.set_bit(B_PP, 1'b1);
    chk_mode(ST_PROGRAM);
    check("prog", 16'h0001, 16'(prog));
    cpu.set_bit(B_PP, 1'b0);
    check("prog", 16'h0000, 16'(prog));
    chk_mode(ST_PSETUP);
    cpu.set_bit(B_PS, 1'b0);
    chk_mode(ST_ENABLE);
    cpu.set_bit(B_ES, 1'b1);
    cpu.set_bit(B_EP, 1'b1);
    chk_mode(ST_ERASE);
    check("erase", 16'h0001, 16'(ers));
    cpu.set_bit(B_EP, 1'b0);
    cpu.set_bit(B_ES, 1'b0);
    chk_mode(ST_ENABLE);
    cpu.set_bit(B_EV, 1'b1);
    chk_mode(ST_EVERIFY);
    cpu.rd_word(18'h00080, w);
    check("eword", 16'hFFFF, w);
    cpu.set_bit(B_EV, 1'b0);
    cpu.set_bit(B_EN, 1'b0);
    chk_mode(ST_IDLE);
  endtask : t_walk
  // Pin dropped mid-pulse: pulse stops at once, state falls to idle
  task t_pin;
    cpu.set_bit(B_EN, 1'b1);
    cpu.set_bit(B_PS, 1'b1);
    cpu.set_bit(B_PP, 1'b1);
    flash_write_enable_pin = 1'b0;
    #1;
    check("prog", 16'h0000, 16'(prog));
    @(negedge ref_clk_i);
    chk_mode(ST_IDLE);
    cpu.set_bit(B_PP, 1'b0);
    cpu.set_bit(B_PS, 1'b0);
    cpu.set_bit(B_EN, 1'b0);
    cpu.set_bit(B_EN, 1'b1);
    chk_mode(ST_IDLE);
    cpu.set_bit(B_EN, 1'b0);
    flash_write_enable_pin = 1'b1;
  endtask : t_pin
  // Short page padded with erased bytes, one pulse, full word verify
  task t_page;
    logic [15:0] w;
    int i;
    cpu.set_bit(B_EN, 1'b1);
    for (i = 0; i < PAGE_BYTES; i++) begin
      cpu.wr_byte(18'h00080 + 18'(i), i < 100 ? 8'(i) : ERASED_BYTE);
    end
    cpu.set_bit(B_PS, 1'b1);
    cpu.set_bit(B_PP, 1'b1);
    cpu.set_bit(B_PP, 1'b0);
    cpu.set_bit(B_PS, 1'b0);
    cpu.set_bit(B_PV, 1'b1);
    chk_mode(ST_PVERIFY);
    for (i = 0; i < PAGE_BYTES; i += 2) begin
      cpu.rd_word(18'h00080 + 18'(i), w);
      check("word", i < 100 ? {8'(i), 8'(i + 1)} : 16'hFFFF, w);
    end
    cpu.rd_word(18'h00083, w);
    check("odd", 16'h0203, w);
    cpu.set_bit(B_PV, 1'b0);
    chk_mode(ST_ENABLE);
    cpu.set_bit(B_EN, 1'b0);
  endtask : t_page
  // Page load then one timed pulse; the width stands for the pulse class
  task burn(input logic use_add, input int width);
    logic [7:0] w8;
    int i;
    for (i = 0; i < PAGE_BYTES; i++) begin
      w8 = use_add ? add_img[i] : rep_img[i];
      cpu.wr_byte(PAGE_BASE + 18'(i), w8);
    end
    cpu.set_bit(B_PS, 1'b1);
    cpu.set_bit(B_PP, 1'b1);
    repeat (width) @(negedge ref_clk_i);
    check("prog", 16'h0001, 16'(prog));
    cpu.set_bit(B_PP, 1'b0);
    cpu.set_bit(B_PS, 1'b0);
  endtask : burn
  // Mid-run reset: idle state, cleared read word, erased cells again
  task t_reset;
    logic [15:0] w;
    @(negedge ref_clk_i);
    reset_n_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    chk_mode(ST_IDLE);
    check("rdata", 16'h0000, rdata);
    check("rvalid", 16'h0000, 16'(rvalid));
    cpu.set_bit(B_EN, 1'b1);
    cpu.set_bit(B_PV, 1'b1);
    cpu.rd_word(PAGE_BASE, w);
    check("erased", 16'hFFFF, w);
    cpu.set_bit(B_PV, 1'b0);
    cpu.set_bit(B_EN, 1'b0);
  endtask : t_reset
  // Program loop on one page with reprogram and extra-pulse masks
  task t_algo;
    logic [7:0]  src [PAGE_BYTES];
    logic [15:0] w;
    logic        done;
    logic        extra;
    int          i;
    int          n;
    for (i = 0; i < PAGE_BYTES; i++) begin
      src[i]     = 8'(i) ^ 8'h5A;
      rep_img[i] = src[i];
    end
    n    = 0;
    done = 1'b0;
    extra = 1'b0;
    while (!done && n < MAX_LOOPS) begin
      n++;
      cpu.set_bit(B_EN, 1'b1);
      burn(1'b0, n <= 6 ? W_EARLY : W_LATE);
      cpu.set_bit(B_PV, 1'b1);
      done  = 1'b1;
      extra = 1'b0;
      for (i = 0; i < PAGE_BYTES; i += 2) begin
        cpu.rd_word(PAGE_BASE + 18'(i), w);
        check("vword", {src[i], src[i + 1]}, w);
        add_img[i]     = rep_img[i] | w[15:8];
        add_img[i + 1] = rep_img[i + 1] | w[7:0];
        rep_img[i]     = src[i] | ~w[15:8];
        rep_img[i + 1] = src[i + 1] | ~w[7:0];
        done  = done && rep_img[i] == 8'hFF && rep_img[i + 1] == 8'hFF;
        extra = extra || add_img[i] != 8'hFF || add_img[i + 1] != 8'hFF;
      end
      cpu.set_bit(B_PV, 1'b0);
      if (extra && n <= 6) begin
        burn(1'b1, W_EXTRA);
      end
      cpu.set_bit(B_EN, 1'b0);
    end
    check("loops", 16'h0001, 16'(n));
    check("done", 16'h0001, 16'(done));
  endtask : t_algo
  task stop_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    t_walk();
    t_pin();
    t_page();
    t_reset();
    t_algo();
    stop_test();
  end
endmodule : test_flash_program_verify_seq

// file: include/flash_pv_pkg.sv
// Summary of operation
// - Array latches each page byte and address
// - Pulse applied while in program state, one cycle behind the pulse bit
// - Program verify read returns latched address word
// - Programming completes within maximum loop count
// - Refuse program or erase without write enable pin
// - Modes apply to range 000000 to 03FFFF
package flash_pv_pkg;
  localparam int          PAGE_BYTES  = 128;
  localparam int          ADDR_W      = 18;
  localparam logic [17:0] FLASH_LAST  = 18'h3FFFF;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  localparam logic [6:0]  PAGE_OFS_0  = 7'h00;
  typedef enum {
    ST_IDLE,
    ST_ENABLE,
    ST_PSETUP,
    ST_PROGRAM,
    ST_ESETUP,
    ST_ERASE,
    ST_PVERIFY,
    ST_EVERIFY
  } mode_st_t;
endpackage : flash_pv_pkg

// file: src/flash_page_latch.sv
`timescale 1ns/100ps
module flash_page_latch
  import flash_pv_pkg::*;
#(
  parameter int DEPTH = PAGE_BYTES
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     wr_i,
  input  wire logic [$clog2(DEPTH)-1:0] idx_i,
  input  wire logic [7:0]               data_i,
  input  wire logic                     pulse_i,
  output logic      [7:0]               cell_data_o [DEPTH]
);
  logic [7:0] page_mem [DEPTH];
  logic [7:0] cell_mem [DEPTH];

  // Page buffer writes and pulse burn; a pulse clears only mask-0 bits
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!reset_n_i) begin
        page_mem[i] <= ERASED_BYTE;
        cell_mem[i] <= ERASED_BYTE;
      end else begin
        if (wr_i && idx_i == i[$clog2(DEPTH)-1:0]) begin
          page_mem[i] <= data_i;
        end
        if (pulse_i) begin
          cell_mem[i] <= cell_mem[i] & page_mem[i];
        end
      end
    end
  end

  // One pulse cycle must leave no page zero bit still erased in cell 0
  burn_full_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    pulse_i && !wr_i |=> (cell_mem[0] & ~page_mem[0]) == 8'h00)
    else $error("pulse left a cell bit erased");

  assign cell_data_o = cell_mem;
endmodule : flash_page_latch

// file: src/flash_program_verify_seq.sv
`timescale 1ns/100ps
module flash_program_verify_seq
  import flash_pv_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              flash_write_enable_pin_i,
  input  wire logic              software_write_enable_i,
  input  wire logic              program_setup_bit_i,
  input  wire logic              program_pulse_bit_i,
  input  wire logic              verify_after_write_bit_i,
  input  wire logic              erase_setup_bit_i,
  input  wire logic              erase_pulse_bit_i,
  input  wire logic              erase_verify_bit_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  output logic      [15:0]       rdata_o,
  output logic                   rvalid_o,
  output logic                   programming_o,
  output logic                   erasing_o,
  output logic [2:0]             mode_o
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    mode_st_t          st;
    logic [ADDR_W-1:0] vaddr;
    logic [15:0]       rdata;
    logic              rvalid;
  } seq_state_t;

  seq_state_t  cur_r;
  seq_state_t  cur_nxt;
  logic [7:0]  cells [PAGE_BYTES];
  logic        in_range;
  logic        page_wr;
  logic        pulse_on;
  logic [6:0]  hi_idx;
  logic [6:0]  lo_idx;

  // Range check for the controlled area
  assign in_range = addr_i <= FLASH_LAST;
  // Page buffer is loaded only in the enable state, whichever mode bits are set
  assign page_wr = wr_i && in_range && cur_r.st == ST_ENABLE;
  // Write pin gates the actual pulse as well as the state
  assign pulse_on = cur_r.st == ST_PROGRAM && flash_write_enable_pin_i;

  flash_page_latch #(
    .DEPTH (PAGE_BYTES)
  ) u_latch (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .wr_i        (page_wr),
    .idx_i       (addr_i[6:0]),
    .data_i      (wdata_i),
    .pulse_i     (pulse_on),
    .cell_data_o (cells)
  );

  // Word pairing: even byte goes high, odd byte low
  assign hi_idx = {cur_r.vaddr[6:1], 1'b0};
  assign lo_idx = {cur_r.vaddr[6:1], 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode; multi-bit combinations take the first bit in priority order,
  // and a pulse is entered only from its setup state, never straight from enable
  always_comb begin
    cur_nxt        = cur_r;
    cur_nxt.rvalid = 1'b0;
    case (cur_r.st)
      ST_IDLE: begin
        if (software_write_enable_i) begin
          cur_nxt.st = ST_ENABLE;
        end
      end
      ST_ENABLE: begin
        if (!software_write_enable_i) begin
          cur_nxt.st = ST_IDLE;
        end else if (program_setup_bit_i) begin
          cur_nxt.st = ST_PSETUP;
        end else if (erase_setup_bit_i) begin
          cur_nxt.st = ST_ESETUP;
        end else if (verify_after_write_bit_i) begin
          cur_nxt.st = ST_PVERIFY;
        end else if (erase_verify_bit_i) begin
          cur_nxt.st = ST_EVERIFY;
        end
      end
      ST_PSETUP: begin
        if (!program_setup_bit_i) begin
          cur_nxt.st = ST_ENABLE;
        end else if (program_pulse_bit_i) begin
          cur_nxt.st = ST_PROGRAM;
        end
      end
      ST_PROGRAM: begin
        if (!program_pulse_bit_i) begin
          cur_nxt.st = ST_PSETUP;
        end
      end
      ST_ESETUP: begin
        if (!erase_setup_bit_i) begin
          cur_nxt.st = ST_ENABLE;
        end else if (erase_pulse_bit_i) begin
          cur_nxt.st = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (!erase_pulse_bit_i) begin
          cur_nxt.st = ST_ESETUP;
        end
      end
      ST_PVERIFY: begin
        if (!verify_after_write_bit_i) begin
          cur_nxt.st = ST_ENABLE;
        end else if (wr_i && in_range) begin
          cur_nxt.vaddr = addr_i;
        end else if (rd_i) begin
          cur_nxt.rdata  = {cells[hi_idx], cells[lo_idx]};
          cur_nxt.rvalid = 1'b1;
        end
      end
      ST_EVERIFY: begin
        if (!erase_verify_bit_i) begin
          cur_nxt.st = ST_ENABLE;
        end else if (rd_i) begin
          cur_nxt.rdata  = {ERASED_BYTE, ERASED_BYTE};
          cur_nxt.rvalid = 1'b1;
        end
      end
      default: begin
        cur_nxt.st = ST_IDLE;
      end
    endcase
    // Dropping the write pin forces protection
    if (!flash_write_enable_pin_i) begin
      cur_nxt.st = ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset returns to idle with the read word cleared
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cur_r <= '{st: ST_IDLE, vaddr: '0, rdata: 16'h0000, rvalid: 1'b0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Pulse outputs stay combinational so a dropped pin cuts them at once
  assign rdata_o       = cur_r.rdata;
  assign rvalid_o      = cur_r.rvalid;
  assign programming_o = pulse_on;
  assign erasing_o     = cur_r.st == ST_ERASE && flash_write_enable_pin_i;
  assign mode_o        = 3'(cur_r.st);

  ////////////////////////////////////////////////////////////////////////////
  // Protocol checks on what the sequencer drives
  pin_low_blocks_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    !flash_write_enable_pin_i |=> !programming_o && !erasing_o)
    else $error("pulse while write pin low");
  pin_low_idle_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    !flash_write_enable_pin_i |=> cur_r.st == ST_IDLE)
    else $error("write pin low left a mode active");
  pulse_follows_bit_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    programming_o |-> $past(program_pulse_bit_i))
    else $error("pulse without pulse bit");
  pulse_ends_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    programming_o && !program_pulse_bit_i |=> !programming_o)
    else $error("pulse outlived bit");
  erase_ends_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    erasing_o && !erase_pulse_bit_i |=> !erasing_o)
    else $error("erase outlived bit");
  setup_first_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    $rose(programming_o) |-> $past(cur_r.st) == ST_PSETUP)
    else $error("pulse without setup");
  enable_first_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    cur_r.st == ST_IDLE |=> cur_r.st inside {ST_IDLE, ST_ENABLE})
    else $error("mode entered without enable");
  verify_read_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    cur_r.st == ST_PVERIFY && verify_after_write_bit_i && !wr_i && rd_i
    |=> rvalid_o ##0 rdata_o == $past({cells[hi_idx], cells[lo_idx]}))
    else $error("verify read wrong");
  dummy_latch_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    cur_r.st == ST_PVERIFY && verify_after_write_bit_i && wr_i
    |=> cur_r.vaddr == $past(addr_i))
    else $error("dummy write address not latched");
  verify_hold_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    !rvalid_o |-> $stable(rdata_o))
    else $error("verify word moved without read");
  reentry_via_enable_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    cur_r.st == ST_PSETUP && !program_setup_bit_i
    && flash_write_enable_pin_i |=> cur_r.st == ST_ENABLE)
    else $error("setup exit skipped enable");
  range_gate_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    page_wr |-> addr_i <= FLASH_LAST)
    else $error("write outside range");
  no_spurious_rvalid_a: assert property (@(posedge ref_clk_i)
    disable iff (!reset_n_i)
    rvalid_o |-> $past(rd_i))
    else $error("rvalid without read");
  // Main scenarios: pulse, verify read, erase, dummy write
  pulse_cov: cover property (@(posedge ref_clk_i) $fell(programming_o));
  verify_cov: cover property (@(posedge ref_clk_i) rvalid_o);
  erase_cov: cover property (@(posedge ref_clk_i) erasing_o);
  dummy_cov: cover property (@(posedge ref_clk_i)
    cur_r.st == ST_PVERIFY && wr_i);
endmodule : flash_program_verify_seq
